//--- core/i2c_addr_pkg.sv
// Constants shared by the I2C address configuration block
package i2c_addr_pkg;
  // Register byte addresses on the APB side
  localparam logic [7:0]  CFG_OFFSET     = 8'h00;
  localparam logic [7:0]  TARGET_OFFSET  = 8'h04;
  localparam logic [7:0]  OWN_OFFSET     = 8'h08;
  localparam logic [7:0]  MASK_OFFSET    = 8'h30;
  localparam logic [7:0]  RAW_OFFSET     = 8'h34;
  localparam logic [7:0]  ENABLE_OFFSET  = 8'h6C;
  localparam int          ADDR_LSB       = 2;
  localparam int          ADDR_MSB       = 7;
  // Target address register fields
  localparam int          TAR_ADDR_MSB   = 9;
  localparam int          TAR_SEL_BIT    = 10;
  localparam int          TAR_SPEC_BIT   = 11;
  localparam int          TAR_IDENT_BIT  = 13;
  // Own address field and short-address width
  localparam int          OWN_ADDR_MSB   = 9;
  localparam int          SHORT_ADDR_MSB = 6;
  // Configuration and enable bits
  localparam int          CFG_SLV10_BIT  = 3;
  localparam int          ENABLE_BIT     = 0;
  // Event bit positions in raw status and mask
  localparam int          ABORT_BIT      = 6;
  // Reset values
  localparam logic [9:0]  ADDR_RESET     = 10'h055;
  localparam logic        SPEC_RESET     = 1'h0;
  localparam logic        SEL_RESET      = 1'h0;
  // Address sent for the special commands
  localparam logic [9:0]  GCALL_ADDR     = 10'h000;
  localparam logic [9:0]  STARTB_ADDR    = 10'h001;
  localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;
  // Special-command mode, Gray coded along normal -> gcall -> startbyte
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_GCALL  = 2'b01,
    MODE_STARTB = 2'b11
  } mode_e;
endpackage : i2c_addr_pkg

//--- core/i2c_address_config.sv
// Address configuration slice of an I2C controller with APB registers
//
// How it works
// - Special bit gates general call, start byte
// - Select counts only if special and not ident
// - Read after general call raises transmit abort
// - General call mode held until special cleared
// - Select zero general call, one start byte
// - Target field addresses master transfers, reset 055
// - Target field ignored during general call
// - Self loopback is one direction only
// - Master never reads from its own slave
// - Own field holds slave address, reset 055
// - Seven-bit mode compares own bits 6:0 only
// - Own register writable only while disabled
// - Target register writable only while disabled
// - Special zero means normal target use
`timescale 1ns/1ps
`default_nettype none
module i2c_address_config
  import i2c_addr_pkg::*;
(
  input  wire logic        CLK,          // System clock, 40 MHz
  input  wire logic        RST,          // Synchronous reset, active high
  input  wire logic        PSEL,         // APB select
  input  wire logic        PENABLE,      // APB access phase
  input  wire logic        PWRITE,       // APB direction, high for write
  input  wire logic [7:0]  PADDR,        // APB byte address
  input  wire logic [31:0] PWDATA,       // APB write data
  output logic      [31:0] PRDATA,       // APB read data
  output logic             PREADY,       // APB ready
  output logic             PSLVERR,      // APB error on unmapped address
  input  wire logic        CMD_VALID,    // Master command strobe
  input  wire logic        CMD_READ,     // Command direction, high for read
  output logic             SEND_VALID,   // Address phase may start
  output logic      [9:0]  SEND_ADDR,    // Address to put on the bus
  output logic             CMD_ABORT,    // Command refused, one pulse
  input  wire logic        RX_ADDR_VALID,// Slave side saw an address
  input  wire logic [9:0]  RX_ADDR,      // Address seen by slave side
  output logic             SLAVE_HIT,    // Seen address is ours, pulse
  output logic             GCALL_MODE,   // General call mode active
  output logic             STARTB_MODE,  // Start byte mode active
  output logic             LOOPBACK,     // Target equals own address, flagged in normal mode only
  output logic             ENABLED,      // Controller enable bit
  output logic             INTR          // Level interrupt
);

  typedef struct packed {
    logic [9:0]  tar_addr;
    logic        tar_sel;
    logic        tar_spec;
    logic        tar_ident;
    logic [9:0]  own_addr;
    logic        slv10;
    logic        enable;
    logic        raw_abort;
    logic        mask_abort;
    mode_e       mode;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        send_valid;
    logic [9:0]  send_addr;
    logic        abort;
    logic        hit;
    logic        loopback;
    logic        intr;
    logic        gcall_flag;
    logic        startb_flag;
  } state_s;

  state_s state_reg;
  state_s state_next;

  // Compare two addresses over seven or ten bits
  function automatic logic addr_match(input logic [9:0] a,
                                      input logic [9:0] b,
                                      input logic       ten);
    logic short_eq;
    short_eq = (a[SHORT_ADDR_MSB:0] == b[SHORT_ADDR_MSB:0]);
    if (ten)
      addr_match = (a == b);
    else
      addr_match = short_eq;
  endfunction : addr_match

  logic       setup_phase;
  logic       wr_access;
  logic [7:0] word_addr;
  logic       mapped;
  logic       self_target;
  logic       abort_event;

  // APB decode; the slave answers in the first access cycle
  assign setup_phase = PSEL && !PENABLE;
  assign wr_access   = PSEL && PENABLE && PWRITE && state_reg.pready;
  assign word_addr   = {PADDR[ADDR_MSB:ADDR_LSB], 2'b00};
  assign mapped      = (word_addr == CFG_OFFSET)    ||
                       (word_addr == TARGET_OFFSET) ||
                       (word_addr == OWN_OFFSET)    ||
                       (word_addr == MASK_OFFSET)   ||
                       (word_addr == RAW_OFFSET)    ||
                       (word_addr == ENABLE_OFFSET);
  assign self_target = addr_match(state_reg.tar_addr, state_reg.own_addr,
                                  state_reg.slv10);

  // Next state of registers, mode and outputs
  always_comb
  begin
    state_next            = state_reg;
    state_next.pready     = 1'b0;
    state_next.pslverr    = 1'b0;
    state_next.send_valid = 1'b0;
    state_next.abort      = 1'b0;
    state_next.hit        = 1'b0;
    abort_event           = 1'b0;

    // Read data is captured in setup so PRDATA can come from a flop
    if (setup_phase)
    begin
      state_next.pready  = 1'b1;
      state_next.pslverr = !mapped;
      state_next.prdata  = ZERO_WORD;
      if (!PWRITE)
      begin
        unique case (word_addr)
          CFG_OFFSET:
            state_next.prdata[CFG_SLV10_BIT] = state_reg.slv10;
          TARGET_OFFSET:
          begin
            // Upper bits stay zero on read
            state_next.prdata[TAR_ADDR_MSB:0] = state_reg.tar_addr;
            state_next.prdata[TAR_SEL_BIT]    = state_reg.tar_sel;
            state_next.prdata[TAR_SPEC_BIT]   = state_reg.tar_spec;
            state_next.prdata[TAR_IDENT_BIT]  = state_reg.tar_ident;
          end
          OWN_OFFSET:
            state_next.prdata[OWN_ADDR_MSB:0] = state_reg.own_addr;
          MASK_OFFSET:
            state_next.prdata[ABORT_BIT] = state_reg.mask_abort;
          RAW_OFFSET:
            state_next.prdata[ABORT_BIT] = state_reg.raw_abort;
          ENABLE_OFFSET:
            state_next.prdata[ENABLE_BIT] = state_reg.enable;
          default:
            state_next.prdata = ZERO_WORD;
        endcase
      end
    end

    // Register writes; address registers are frozen while enabled
    if (wr_access)
    begin
      unique case (word_addr)
        CFG_OFFSET:
          if (!state_reg.enable)
            state_next.slv10 = PWDATA[CFG_SLV10_BIT];
        TARGET_OFFSET:
          if (!state_reg.enable)
          begin
            state_next.tar_addr  = PWDATA[TAR_ADDR_MSB:0];
            state_next.tar_sel   = PWDATA[TAR_SEL_BIT];
            state_next.tar_spec  = PWDATA[TAR_SPEC_BIT];
            state_next.tar_ident = PWDATA[TAR_IDENT_BIT];
          end
        OWN_OFFSET:
          if (!state_reg.enable)
            state_next.own_addr = PWDATA[OWN_ADDR_MSB:0];
        MASK_OFFSET:
          state_next.mask_abort = PWDATA[ABORT_BIT];
        RAW_OFFSET:
          if (PWDATA[ABORT_BIT])
            state_next.raw_abort = 1'b0;
        ENABLE_OFFSET:
          state_next.enable = PWDATA[ENABLE_BIT];
        default:
          state_next.enable = state_reg.enable;
      endcase
    end

    // Special command mode; general call is left only by clearing special
    unique case (state_reg.mode)
      MODE_NORMAL:
        if (state_reg.tar_spec && !state_reg.tar_ident)
          state_next.mode = state_reg.tar_sel ? MODE_STARTB
                                              : MODE_GCALL;
      MODE_GCALL:
        if (!state_reg.tar_spec)
          state_next.mode = MODE_NORMAL;
      MODE_STARTB:
        if (!state_reg.tar_spec || state_reg.tar_ident ||
            !state_reg.tar_sel)
          state_next.mode = MODE_NORMAL;
      default:
        state_next.mode = MODE_NORMAL;
    endcase

    // Master command: pick the address or refuse the command
    if (CMD_VALID && state_reg.enable)
    begin
      if (CMD_READ && state_reg.mode == MODE_GCALL)
        abort_event = 1'b1;
      else if (CMD_READ && state_reg.mode == MODE_NORMAL && self_target)
        abort_event = 1'b1;
      else
      begin
        state_next.send_valid = 1'b1;
        unique case (state_reg.mode)
          MODE_GCALL:
            state_next.send_addr = GCALL_ADDR;
          MODE_STARTB:
            state_next.send_addr = STARTB_ADDR;
          default:
            state_next.send_addr = state_reg.tar_addr;
        endcase
      end
    end
    state_next.abort = abort_event;

    // Sticky abort flag; a new event beats a same-cycle clear
    if (abort_event)
      state_next.raw_abort = 1'b1;

    // Slave side address match
    if (RX_ADDR_VALID && state_reg.enable)
      state_next.hit = addr_match(RX_ADDR, state_reg.own_addr,
                                  state_reg.slv10);

    // Loopback only flags the condition; reads to self are refused above
    state_next.loopback = self_target && state_reg.mode == MODE_NORMAL;
    state_next.intr     = state_next.raw_abort && state_next.mask_abort;

    // Mode flags kept in flops beside the mode, so the outputs need no decode
    state_next.gcall_flag  = state_next.mode == MODE_GCALL;
    state_next.startb_flag = state_next.mode == MODE_STARTB;
  end

  // State register with synchronous reset
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      state_reg            <= '0;
      state_reg.tar_addr   <= ADDR_RESET;
      state_reg.own_addr   <= ADDR_RESET;
      state_reg.tar_spec   <= SPEC_RESET;
      state_reg.tar_sel    <= SEL_RESET;
      state_reg.mode       <= MODE_NORMAL;
    end
    else
      state_reg <= state_next;
  end

  // Outputs straight from the state flops
  assign PRDATA      = state_reg.prdata;
  assign PREADY      = state_reg.pready;
  assign PSLVERR     = state_reg.pslverr;
  assign SEND_VALID  = state_reg.send_valid;
  assign SEND_ADDR   = state_reg.send_addr;
  assign CMD_ABORT   = state_reg.abort;
  assign SLAVE_HIT   = state_reg.hit;
  assign GCALL_MODE  = state_reg.gcall_flag;
  assign STARTB_MODE = state_reg.startb_flag;
  assign LOOPBACK    = state_reg.loopback;
  assign ENABLED     = state_reg.enable;
  assign INTR        = state_reg.intr;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  // Checks on the address and command behaviour
  a_gc_read_abort: assert property (
    CMD_VALID && CMD_READ && ENABLED && GCALL_MODE
    |=> CMD_ABORT && !SEND_VALID && state_reg.raw_abort)
    else $error("read in general call not aborted");

  a_gc_addr_used: assert property (
    CMD_VALID && !CMD_READ && ENABLED && GCALL_MODE
    |=> SEND_VALID && SEND_ADDR == GCALL_ADDR)
    else $error("general call address not sent");

  a_startb_addr: assert property (
    CMD_VALID && ENABLED && STARTB_MODE
    |=> SEND_VALID && SEND_ADDR == STARTB_ADDR)
    else $error("start byte address not sent");

  a_normal_target: assert property (
    CMD_VALID && !CMD_READ && ENABLED && state_reg.mode == MODE_NORMAL
    |=> SEND_VALID && SEND_ADDR == $past(state_reg.tar_addr))
    else $error("target address not used");

  a_gc_mode_held: assert property (
    GCALL_MODE && state_reg.tar_spec |=> GCALL_MODE)
    else $error("general call mode left while special set");

  a_special_off: assert property (
    !state_reg.tar_spec [*2] |-> state_reg.mode == MODE_NORMAL)
    else $error("special mode without special bit");

  a_ident_blocks: assert property (
    (state_reg.tar_ident && !GCALL_MODE) [*2]
    |-> state_reg.mode == MODE_NORMAL)
    else $error("select acted with ident set");

  a_own_frozen: assert property (
    ENABLED |=> $stable(state_reg.own_addr))
    else $error("own address changed while enabled");

  a_tar_frozen: assert property (
    ENABLED |=> $stable(state_reg.tar_addr) && $stable(state_reg.tar_spec))
    else $error("target changed while enabled");

  a_self_read: assert property (
    CMD_VALID && CMD_READ && ENABLED && state_reg.mode == MODE_NORMAL &&
    self_target |=> CMD_ABORT)
    else $error("read from own slave not refused");

  a_short_match: assert property (
    RX_ADDR_VALID && ENABLED && !state_reg.slv10 &&
    RX_ADDR[SHORT_ADDR_MSB:0] == state_reg.own_addr[SHORT_ADDR_MSB:0]
    |=> SLAVE_HIT)
    else $error("seven-bit match missed");

  a_reserved_zero: assert property (
    PREADY |-> PRDATA[31:14] == 18'h00000)
    else $error("reserved bits read nonzero");

  a_apb_ready: assert property (
    PSEL && !PENABLE |=> PREADY ##1 !PREADY)
    else $error("apb answer not one cycle");

  // Mode flag outputs always agree with the registered mode
  a_mode_flags: assert property (
    (GCALL_MODE == (state_reg.mode == MODE_GCALL)) &&
    (STARTB_MODE == (state_reg.mode == MODE_STARTB)))
    else $error("mode flags disagree with mode");

  c_gc_abort:   cover property (GCALL_MODE && CMD_ABORT);
  c_startb:     cover property (STARTB_MODE && SEND_VALID);
  c_hit:        cover property (SLAVE_HIT);
  c_intr:       cover property (INTR ##1 !INTR);
  c_loopback:   cover property (LOOPBACK && SEND_VALID);

endmodule : i2c_address_config
`default_nettype wire

//--- verification/i2c_bus_model.sv
// Far-side bus model: other masters whose addresses reach our slave side
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_model
(
  input  wire logic       clk,                 // System clock
  input  wire logic       req,                 // Put one address on the bus
  input  wire logic [9:0] addr,                // Address another master sends
  output logic            seen_valid = 1'b0,   // One-cycle address strobe
  output logic      [9:0] seen_addr  = 10'h2AA // Address seen on the bus
);
  // Outside a strobe the lines toggle between the last address and its complement
  always @(posedge clk)
  begin
    seen_valid <= req;
    seen_addr  <= req ? addr : ~seen_addr;
  end
endmodule : i2c_bus_model
`default_nettype wire

//--- verification/tb.sv
// Self-checking bench for the I2C address configuration block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import i2c_addr_pkg::*;
  logic CLK, RST, PSEL, PENABLE, PWRITE, CMD_VALID, CMD_READ, REQ;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rnd;
  logic PREADY, PSLVERR, SEND_VALID, CMD_ABORT, RX_ADDR_VALID, SLAVE_HIT;
  logic GCALL_MODE, STARTB_MODE, LOOPBACK, ENABLED, INTR;
  logic [9:0] SEND_ADDR, RX_ADDR, REQ_ADDR, a, own;
  logic [32:0] apbq[$];
  logic [10:0] cmdq[$];
  int mismatches, check_count, cycles, i;

  i2c_address_config i_dut (.CLK(CLK), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .CMD_VALID(CMD_VALID), .CMD_READ(CMD_READ), .SEND_VALID(SEND_VALID),
    .SEND_ADDR(SEND_ADDR), .CMD_ABORT(CMD_ABORT),
    .RX_ADDR_VALID(RX_ADDR_VALID), .RX_ADDR(RX_ADDR),
    .SLAVE_HIT(SLAVE_HIT), .GCALL_MODE(GCALL_MODE),
    .STARTB_MODE(STARTB_MODE), .LOOPBACK(LOOPBACK), .ENABLED(ENABLED),
    .INTR(INTR));
  i2c_bus_model i_bus (.clk(CLK), .req(REQ), .addr(REQ_ADDR),
    .seen_valid(RX_ADDR_VALID), .seen_addr(RX_ADDR));

  // 40 MHz system clock
  initial
  begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task check(input string nm, input logic [32:0] seen, input logic [32:0] e);
    check_count++;
    if (seen !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, seen);
    end
  endtask : check

  task test_done;
    mismatches += apbq.size() + cmdq.size(); // Unanswered requests fail too
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  // APB master: hold the request until PREADY, then one idle cycle
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
           input logic [32:0] e);
    apbq.push_back(e);
    PSEL    <= 1'b1;
    PWRITE  <= w;
    PADDR   <= ad;
    PWDATA  <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask : apb

  task wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d, 33'h0);
  endtask : wr

  task rd(input logic [7:0] ad, input logic [31:0] e);
    apb(1'b0, ad, ZERO_WORD, {1'b0, e});
  endtask : rd

  // Target register only takes writes while disabled
  task set_tar(input logic [31:0] v);
    wr(ENABLE_OFFSET, ZERO_WORD);
    wr(TARGET_OFFSET, v);
    wr(ENABLE_OFFSET, 32'h1);
  endtask : set_tar

  task cmd(input logic rd_cmd, input logic [10:0] e);
    cmdq.push_back(e);
    CMD_VALID <= 1'b1;
    CMD_READ  <= rd_cmd;
    @(posedge CLK);
    CMD_VALID <= 1'b0;
    repeat (2) @(posedge CLK);
  endtask : cmd

  task rx(input logic [9:0] ad, input logic e);
    REQ      <= 1'b1;
    REQ_ADDR <= ad;
    @(posedge CLK);
    REQ      <= 1'b0;
    repeat (2) @(posedge CLK);
    check("slave_hit", {32'h0, SLAVE_HIT}, {32'h0, e});
  endtask : rx

  // Result monitors take the oldest expectation for each answer
  always @(posedge CLK)
  begin
    if (PREADY === 1'b1)
      check("apb", {PSLVERR, PRDATA},
            apbq.pop_front());
    if (SEND_VALID === 1'b1 || CMD_ABORT === 1'b1)
      check("command", {22'h0, CMD_ABORT, CMD_ABORT ? 10'h0 : SEND_ADDR},
        {22'h0, cmdq.pop_front()});
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      mismatches++;
      test_done();
    end
  end

  initial
  begin
    {RST, PSEL, PENABLE, PWRITE, CMD_VALID, CMD_READ, REQ} = 7'h40;
    {PADDR, PWDATA, REQ_ADDR} = '0;
    rnd = 32'h2963;
    own = 10'h323;
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    rd(TARGET_OFFSET, 32'h055);
    rd(OWN_OFFSET, 32'h055);
    apb(1'b0, 8'h50, ZERO_WORD, {1'b1, ZERO_WORD});
    apb(1'b1, 8'h50, 32'hFFFF_FFFF, {1'b1, ZERO_WORD});
    $display("test reset done");
    // Reserved bits set on purpose, then writes while enabled
    wr(TARGET_OFFSET, 32'hFFFF_D03A);
    wr(OWN_OFFSET, 32'hFFFF_FC00 | own);
    rd(TARGET_OFFSET, 32'h03A);
    rd(OWN_OFFSET, {22'h0, own});
    wr(ENABLE_OFFSET, 32'h1);
    wr(TARGET_OFFSET, 32'h011);
    wr(OWN_OFFSET, 32'h044);
    rd(TARGET_OFFSET, 32'h03A);
    rd(OWN_OFFSET, {22'h0, own});
    wr(MASK_OFFSET, 32'h40);
    check("enabled", {32'h0, ENABLED}, 33'h1);
    $display("test registers done");
    // Random legal targets; select alone must not matter
    for (i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      a = 10'h008 + 10'(rnd[15:0] % 16'd112);
      if (a[6:0] == own[6:0])
        a = 10'h024;
      set_tar({21'h0, i[0], a});
      cmd(1'b0, {1'b0, a});
      cmd(1'b1, {1'b0, a});
    end
    $display("test normal done");
    // General call: target ignored, reads refused, mode sticks
    set_tar(32'h083A);
    check("mode", {31'h0, STARTB_MODE, GCALL_MODE}, 33'h1);
    cmd(1'b0, {1'b0, GCALL_ADDR});
    cmd(1'b1, 11'h400);
    check("intr", {32'h0, INTR}, 33'h1);
    rd(RAW_OFFSET, 32'h40);
    wr(RAW_OFFSET, 32'h40);
    repeat (2) @(posedge CLK);
    check("intr", {32'h0, INTR}, 33'h0);
    set_tar(32'h0C3A);
    check("mode", {31'h0, STARTB_MODE, GCALL_MODE}, 33'h1);
    cmd(1'b0, {1'b0, GCALL_ADDR});
    set_tar(32'h003A);
    check("mode", {31'h0, STARTB_MODE, GCALL_MODE}, 33'h0);
    cmd(1'b0, 11'h03A);
    // Start byte from a single target write
    set_tar(32'h0C3A);
    check("mode", {31'h0, STARTB_MODE, GCALL_MODE}, 33'h2);
    cmd(1'b0, {1'b0, STARTB_ADDR});
    cmd(1'b0, {1'b0, STARTB_ADDR});
    set_tar(32'h2C3A);
    cmd(1'b0, 11'h03A);
    $display("test special done");
    // Target equals own address: simplex loopback only
    set_tar({22'h0, own});
    check("loopback", {32'h0, LOOPBACK}, 33'h1);
    cmd(1'b0, {1'b0, own});
    cmd(1'b1, 11'h400);
    $display("test loopback done");
    // Slave match in 7-bit, then 10-bit addressing
    rx(10'h0A3, 1'b1);
    rx(10'h324, 1'b0);
    wr(ENABLE_OFFSET, ZERO_WORD);
    wr(CFG_OFFSET, 32'h8);
    wr(ENABLE_OFFSET, 32'h1);
    rx(10'h0A3, 1'b0);
    rx(own, 1'b1);
    $display("test slave done");
    // Reset in mid-run: enable, interrupt and both addresses go back
    RST <= 1'b1;
    repeat (3) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    check("intr", {32'h0, INTR}, 33'h0);
    check("enabled", {32'h0, ENABLED}, 33'h0);
    rd(TARGET_OFFSET, 32'h055);
    rd(OWN_OFFSET, 32'h055);
    $display("test midreset done");
    test_done();
  end
endmodule : tb
`default_nettype wire
